// File: oscsel_pkg.sv
// Package for the oscillator select and PLL divider block.
// Assumes a single 250 MHz system clock and an APB register port.
package oscsel_pkg;

	// Source codes of the initial source select field
	typedef enum logic [2:0] {
		SRC_FRC = 3'h0,
		SRC_FRC_PLL = 3'h1,
		SRC_PRI = 3'h2,
		SRC_PRI_PLL = 3'h3,
		SRC_SEC = 3'h4,
		SRC_LOW_POWER_INTERNAL_RC = 3'h5,
		SRC_FRC_DIV16 = 3'h6,
		SRC_FRC_DIVN = 3'h7
	} oscsel_src_e;

	// Primary mode field codes
	localparam logic [1:0] PRI_EXT_CLK = 2'h0;
	localparam logic [1:0] PRI_XTAL = 2'h1;
	localparam logic [1:0] PRI_HS_XTAL = 2'h2;

	// Register byte offsets
	localparam logic [7:0] ADDR_CLOCK_DIVISOR_REG = 8'h00;
	localparam logic [7:0] ADDR_FEEDBACK_DIVISOR_REG = 8'h04;
	localparam logic [7:0] ADDR_TUNE = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;

	// Divisor register fields
	localparam int FAST_RC_POSTSCALE_SEL_LSB = 8;
	localparam int POST_LSB = 6;
	localparam int PRE_LSB = 0;
	localparam logic [2:0] FAST_RC_POSTSCALE_SEL_RST = 3'h0;
	localparam logic [1:0] POST_RST = 2'h1;
	localparam logic [4:0] PRE_RST = 5'h00;
	localparam logic [8:0] FBD_RST = 9'h030;
	localparam logic [5:0] TUNE_RST = 6'h00;

	// Postscale codes
	localparam logic [1:0] POST_DIV2 = 2'h0;
	localparam logic [1:0] POST_DIV4 = 2'h1;
	localparam logic [1:0] POST_DIV8 = 2'h3;

	// Offset added to prescale and feedback codes
	localparam int CODE_OFFSET = 2;
	// Fixed divider of the divide-by-16 mode
	localparam int FRC_FIXED_DIV = 16;

endpackage : oscsel_pkg

// File: oscsel_div.sv
// Programmable divider producing a one-cycle enable pulse.
// Assumes enables on the same clock; divisor compared on every cycle, not sampled.
`timescale 1ns/1ps
module oscsel_div
	import oscsel_pkg::*;
#(
	parameter int W = 10
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Input enable and divisor (1 passes every input pulse)
	input wire logic in_en,
	input wire logic [W-1:0] divisor,
	// Output enable pulse
	output logic out_en
);
	logic [W-1:0] cnt_ff;

	if (W < 2)
	begin : g_bad_width
		$error("oscsel_div width too small");
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_ff <= '0;
		else if (in_en)
		begin
			if (cnt_ff + W'(1) >= divisor)
				cnt_ff <= '0;
			else
				cnt_ff <= cnt_ff + W'(1);
		end
	end

	assign out_en = in_en && (cnt_ff + W'(1) >= divisor);

endmodule : oscsel_div

// File: oscsel_top.sv
// Clock source selection, fast RC postscaler, PLL ratio and halving.
// Oscillators appear as enable pulses on mclk; the PLL is modelled as
// a rate multiplier of enable pulses on the 250 MHz clock.
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - Fast RC clock divided by postscale field bits 10:8 of divisor reg.
// RULE_02 - At power-on, source chosen from source select and primary mode.
// RULE_03 - Erased configuration selects fast RC divide-by-N, code 111.
// RULE_04 - Oscillator or PLL output halved gives instruction clock.
// RULE_05 - PLL input divided by prescale 2..33 from bits 4:0.
// RULE_06 - VCO input multiplied by nine-bit feedback field plus offset.
// RULE_07 - VCO output divided by 2, 4 or 8 from bits 7:6.
// RULE_08 - PLL output equals input times feedback over prescale times post.
// RULE_09 - PLL available only to primary and fast RC sources.
// RULE_10 - Software keeps VCO input between 0.8 and 8 MHz.
// RULE_11 - Software keeps VCO output between 100 and 200 MHz.
// RULE_12 - Software keeps PLL output between 12.5 and 80 MHz.
// RULE_13 - Source select codes decode to the eight oscillator modes.
// RULE_14 - Primary mode field decoded only in primary modes.
// RULE_15 - Low-power RC clock also feeds watchdog and clock monitor.
// RULE_16 - Second primary pin function set by a configuration bit.
// RULE_17 - Software tunes the fast RC through a tuning register.
// RULE_18 - Auxiliary oscillator clock independent of system clock.
// RULE_19 - Postscale codes 00,01,11 give 2,4,8; 10 is reserved.
// RULE_20 - Prescale factor equals field plus two, reset two.
// RULE_21 - Feedback factor equals field plus two, reset fifty.
// RULE_22 - Fast RC postscale codes give 1,2,4,...,64,256; reset one.
// RULE_23 - Divide-by-16 mode uses fixed sixteen ignoring the field.
// RULE_24 - PLL modes present PLL output to the halving stage.
module oscsel_top
	import oscsel_pkg::*;
#(
	parameter int FBD_W = 9
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Non-volatile configuration (erased reads all ones)
	input wire logic [2:0] initial_source_sel,
	input wire logic [1:0] primary_mode_sel,
	input wire logic second_pin_function_cfg,
	// Oscillator ticks from pins or analog cells (asynchronous)
	input wire logic fast_internal_rc_tick,
	input wire logic primary_input_pin,
	input wire logic secondary_input_pin,
	input wire logic low_power_internal_rc_tick,
	input wire logic auxiliary_source_tick,
	// Clock enables
	output logic osc_clk_en,
	output logic instr_clk_en,
	output logic peripheral_time_base_en,
	output logic low_power_internal_rc_ref_en,
	output logic aux_clk_en,
	// Source status and pin control
	output logic [2:0] active_source,
	output logic pll_active,
	output logic primary_output_pin_is_io,
	output logic primary_xtal_drive,
	output logic primary_hs_gain,
	output logic [5:0] fast_rc_tune
);
	localparam int MUL_W = FBD_W + 1;
	localparam int ACC_W = MUL_W + 8;

	if (FBD_W != 9)
	begin : g_bad_fbd_width
		$error("oscsel_top supports a nine-bit feedback field");
	end

	// Synchronised oscillator inputs
	logic [4:0] raw_in;
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic [4:0] sync3_ff;
	logic [4:0] tick;

	assign raw_in = {auxiliary_source_tick, low_power_internal_rc_tick,
		secondary_input_pin, primary_input_pin, fast_internal_rc_tick};

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end
		else
		begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// Rising edges become one-cycle ticks
	assign tick = sync2_ff & ~sync3_ff;

	// Power-on latch of configuration after reset release
	logic cfg_taken_ff;
	oscsel_src_e src_ff;
	logic [1:0] pmode_ff;
	logic pin_io_ff;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg_taken_ff <= 1'b0;
			src_ff <= SRC_FRC_DIVN;
			pmode_ff <= PRI_EXT_CLK;
			pin_io_ff <= 1'b0;
		end
		else if (!cfg_taken_ff)
		begin
			cfg_taken_ff <= 1'b1;
			src_ff <= oscsel_src_e'(initial_source_sel); // RULE_02
			pmode_ff <= primary_mode_sel; // RULE_02
			pin_io_ff <= second_pin_function_cfg;
		end
	end

	// Registers
	logic [2:0] fast_rc_postscale_sel_ff;
	logic [1:0] post_ff;
	logic [4:0] pre_ff;
	logic [8:0] fbd_ff;
	logic [5:0] tune_ff;
	logic wr_en;
	logic acc;

	assign acc = psel && penable;
	assign wr_en = acc && pwrite;
	assign pready = psel && penable;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fast_rc_postscale_sel_ff <= FAST_RC_POSTSCALE_SEL_RST; // RULE_22
			post_ff <= POST_RST;
			pre_ff <= PRE_RST; // RULE_20
			fbd_ff <= FBD_RST; // RULE_21
		end
		else if (wr_en && paddr == ADDR_CLOCK_DIVISOR_REG)
		begin
			fast_rc_postscale_sel_ff <= pwdata[FAST_RC_POSTSCALE_SEL_LSB +: 3]; // RULE_01
			post_ff <= pwdata[POST_LSB +: 2]; // RULE_07
			pre_ff <= pwdata[PRE_LSB +: 5]; // RULE_05
		end
		else if (wr_en && paddr == ADDR_FEEDBACK_DIVISOR_REG)
			fbd_ff <= pwdata[8:0]; // RULE_06
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			tune_ff <= TUNE_RST;
		else if (wr_en && paddr == ADDR_TUNE)
			tune_ff <= pwdata[5:0]; // RULE_17
	end

	assign fast_rc_tune = tune_ff; // RULE_17

	logic addr_ok;
	always_comb
	begin
		addr_ok = 1'b1;
		if (paddr == ADDR_CLOCK_DIVISOR_REG)
			addr_ok = 1'b1;
		else if (paddr == ADDR_FEEDBACK_DIVISOR_REG)
			addr_ok = 1'b1;
		else if (paddr == ADDR_TUNE)
			addr_ok = 1'b1;
		else if (paddr == ADDR_STATUS)
			addr_ok = !pwrite;
		else
			addr_ok = 1'b0;
	end

	assign pslverr = acc && !addr_ok;

	logic [31:0] nxt_prdata;
	logic [31:0] prdata_ff;
	always_comb
	begin
		nxt_prdata = 32'h0;
		if (paddr == ADDR_CLOCK_DIVISOR_REG)
			nxt_prdata = {21'h0, fast_rc_postscale_sel_ff, post_ff, 1'b0, pre_ff};
		else if (paddr == ADDR_FEEDBACK_DIVISOR_REG)
			nxt_prdata = {23'h0, fbd_ff};
		else if (paddr == ADDR_TUNE)
			nxt_prdata = {26'h0, tune_ff};
		else if (paddr == ADDR_STATUS)
			nxt_prdata = {25'h0, pin_io_ff, pll_active, pmode_ff, src_ff};
		else
			nxt_prdata = 32'h0;
	end

	// Read data registered in the setup cycle, valid in the access cycle
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			prdata_ff <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata_ff <= nxt_prdata;
	end

	assign prdata = prdata_ff;

	// Source decode
	logic is_frc_src;
	logic is_pri_src;
	logic use_pll;
	logic div16_mode;
	logic divn_mode;

	always_comb
	begin
		is_frc_src = 1'b0;
		is_pri_src = 1'b0;
		use_pll = 1'b0;
		div16_mode = 1'b0;
		divn_mode = 1'b0;
		case (src_ff) // RULE_13
			SRC_FRC: is_frc_src = 1'b1;
			SRC_FRC_PLL:
			begin
				is_frc_src = 1'b1;
				use_pll = 1'b1; // RULE_09
			end
			SRC_PRI: is_pri_src = 1'b1;
			SRC_PRI_PLL:
			begin
				is_pri_src = 1'b1;
				use_pll = 1'b1; // RULE_09
			end
			SRC_FRC_DIV16:
			begin
				is_frc_src = 1'b1;
				div16_mode = 1'b1;
			end
			SRC_FRC_DIVN:
			begin
				is_frc_src = 1'b1;
				divn_mode = 1'b1; // RULE_03
			end
			default: ;
		endcase
	end

	// Primary mode only meaningful for primary sources
	assign primary_xtal_drive = is_pri_src &&
		(pmode_ff == PRI_XTAL || pmode_ff == PRI_HS_XTAL); // RULE_14
	assign primary_hs_gain = is_pri_src && pmode_ff == PRI_HS_XTAL; // RULE_14
	// Crystal modes own the second pin; others follow the config bit
	assign primary_output_pin_is_io = !primary_xtal_drive && pin_io_ff; // RULE_16

	// Fast RC postscaler
	logic [8:0] frc_divisor;
	always_comb
	begin
		frc_divisor = 9'h001;
		if (div16_mode)
			frc_divisor = 9'(FRC_FIXED_DIV); // RULE_23
		else if (divn_mode)
		begin
			if (fast_rc_postscale_sel_ff == 3'h7)
				frc_divisor = 9'h100; // RULE_22
			else
				frc_divisor = 9'h001 << fast_rc_postscale_sel_ff; // RULE_01
		end
	end

	logic frc_post_en;
	oscsel_div #(.W(9)) u_frc_div (
		.mclk(mclk),
		.arst_n(arst_n),
		.in_en(tick[0]),
		.divisor(frc_divisor),
		.out_en(frc_post_en)
	);

	// PLL input select and prescale
	logic pll_in_en;
	logic vco_in_en;
	logic [5:0] pre_factor;
	assign pll_in_en = use_pll && (is_frc_src ? tick[0] : tick[1]); // RULE_09
	assign pre_factor = 6'(pre_ff) + 6'(CODE_OFFSET); // RULE_20

	oscsel_div #(.W(6)) u_pre_div (
		.mclk(mclk),
		.arst_n(arst_n),
		.in_en(pll_in_en),
		.divisor(pre_factor),
		.out_en(vco_in_en)
	); // RULE_05

	// VCO: each input pulse deposits M credits, drained one per cycle
	logic [MUL_W-1:0] mul_factor;
	logic [ACC_W-1:0] credit_ff;
	logic vco_en;
	assign mul_factor = MUL_W'(fbd_ff) + MUL_W'(CODE_OFFSET); // RULE_21
	assign vco_en = credit_ff != '0;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			credit_ff <= '0;
		else
			credit_ff <= credit_ff + (vco_in_en ? ACC_W'(mul_factor) : '0)
				- ACC_W'(vco_en); // RULE_06
	end

	// Postscale decode
	logic [3:0] post_factor;
	always_comb
	begin
		case (post_ff) // RULE_19
			POST_DIV2: post_factor = 4'h2;
			POST_DIV4: post_factor = 4'h4;
			POST_DIV8: post_factor = 4'h8;
			default: post_factor = 4'h4;
		endcase
	end

	logic pll_out_en;
	oscsel_div #(.W(4)) u_post_div (
		.mclk(mclk),
		.arst_n(arst_n),
		.in_en(vco_en),
		.divisor(post_factor),
		.out_en(pll_out_en)
	); // RULE_07 RULE_08

	// System oscillator select
	logic nxt_osc_en;
	always_comb
	begin
		nxt_osc_en = 1'b0;
		if (use_pll)
			nxt_osc_en = pll_out_en; // RULE_24
		else if (is_frc_src)
			nxt_osc_en = frc_post_en;
		else if (is_pri_src)
			nxt_osc_en = tick[1];
		else if (src_ff == SRC_SEC)
			nxt_osc_en = tick[2];
		else
			nxt_osc_en = tick[3];
	end

	// Halving stage
	logic half_ff;
	logic osc_en_ff;
	logic instr_en_ff;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			half_ff <= 1'b0;
			osc_en_ff <= 1'b0;
			instr_en_ff <= 1'b0;
		end
		else
		begin
			osc_en_ff <= nxt_osc_en;
			instr_en_ff <= nxt_osc_en && half_ff; // RULE_04
			if (nxt_osc_en)
				half_ff <= !half_ff; // RULE_04
		end
	end

	assign osc_clk_en = osc_en_ff;
	assign instr_clk_en = instr_en_ff;
	assign peripheral_time_base_en = instr_en_ff; // RULE_04

	// Reference and auxiliary clocks
	logic low_power_internal_rc_ff;
	logic aux_ff;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			low_power_internal_rc_ff <= 1'b0;
			aux_ff <= 1'b0;
		end
		else
		begin
			low_power_internal_rc_ff <= tick[3]; // RULE_15
			aux_ff <= tick[4]; // RULE_18
		end
	end

	assign low_power_internal_rc_ref_en = low_power_internal_rc_ff;
	assign aux_clk_en = aux_ff;
	assign active_source = src_ff;
	assign pll_active = use_pll;

endmodule : oscsel_top

// File: oscsel_chk_assertions.sv
// Port checker of the oscillator select block.
// Assumes one mclk domain with asynchronous active-low reset.
`timescale 1ns/1ps
module oscsel_chk
	import oscsel_pkg::*;
#(
	parameter int FBD_W = 9
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Enables and status
	input wire logic osc_clk_en,
	input wire logic instr_clk_en,
	input wire logic peripheral_time_base_en,
	input wire logic low_power_internal_rc_ref_en,
	input wire logic [2:0] active_source,
	input wire logic pll_active,
	input wire logic primary_hs_gain,
	input wire logic [5:0] fast_rc_tune
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_tune_wr;
		s_acc ##0 (pwrite && paddr == ADDR_TUNE);
	endsequence
	// Config latch settles one edge after release
	sequence s_run;
		arst_n && $past(arst_n, 2);
	endsequence
	sequence s_quiet;
		!osc_clk_en [*8];
	endsequence

	a_zero_wait: assert property (s_acc |-> pready)
		else $error("no pready in access");
	a_unmapped_err: assert property (
		s_acc ##0 (paddr > ADDR_STATUS) |-> pslverr)
		else $error("no error on unmapped");
	a_tune_write: assert property (s_tune_wr |=>
		fast_rc_tune == $past(pwdata[5:0]))
		else $error("tune not written");
	a_instr_gap: assert property (
		instr_clk_en |=> !instr_clk_en)
		else $error("instr pulses adjacent");
	a_periph_same: assert property (
		instr_clk_en == peripheral_time_base_en)
		else $error("periph differs");
	a_pll_decode: assert property (s_run |-> pll_active ==
		(active_source == SRC_FRC_PLL || active_source == SRC_PRI_PLL))
		else $error("pll flag wrong");
	a_hs_primary: assert property (s_run ##0 primary_hs_gain |->
		active_source inside {SRC_PRI, SRC_PRI_PLL})
		else $error("hs gain off primary");
	a_source_held: assert property (
		s_run |-> $stable(active_source))
		else $error("source changed");
	a_div16_gap: assert property (
		active_source == SRC_FRC_DIV16 && osc_clk_en |=> s_quiet)
		else $error("div16 too fast");
	a_low_power_internal_rc_single: assert property (
		low_power_internal_rc_ref_en |=> !low_power_internal_rc_ref_en)
		else $error("low_power_internal_rc pulses adjacent");
endmodule : oscsel_chk

bind oscsel_top oscsel_chk #(.FBD_W(FBD_W)) oscsel_chk_inst (
	.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .osc_clk_en, .instr_clk_en,
	.peripheral_time_base_en, .low_power_internal_rc_ref_en, .active_source,
	.pll_active, .primary_hs_gain, .fast_rc_tune
);

// File: oscsel_osc_model.sv
// Free-running oscillators and crystals at the clock pins.
// Assumes half periods are multiples of 4 ns, on mclk falling edges, off rising edges.
`timescale 1ns/1ps
module oscsel_osc_model
#(
	parameter int HF = 20,
	parameter int HP = 24,
	parameter int HS = 32,
	parameter int HL = 40,
	parameter int HA = 28
)
(
	// Oscillator levels
	output logic fast_internal_rc_tick,
	output logic primary_input_pin,
	output logic secondary_input_pin,
	output logic low_power_internal_rc_tick,
	output logic auxiliary_source_tick
);
	int t = 0;
	always #1 t = t + 1;
	assign fast_internal_rc_tick = 1'((t / HF) % 2);
	assign primary_input_pin = 1'((t / HP) % 2);
	assign secondary_input_pin = 1'((t / HS) % 2);
	assign low_power_internal_rc_tick = 1'((t / HL) % 2);
	assign auxiliary_source_tick = 1'((t / HA) % 2);
endmodule : oscsel_osc_model

// File: oscsel_top_test.sv
// Self-checking bench of the oscillator select block.
// Assumes the oscillator model and the bound checker.
`timescale 1ns/1ps
module oscsel_top_test
	import oscsel_pkg::*;
	;
	logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] initial_source_sel, active_source, v;
	logic [1:0] primary_mode_sel;
	logic second_pin_function_cfg, fast_internal_rc_tick;
	logic primary_input_pin, secondary_input_pin, auxiliary_source_tick;
	logic low_power_internal_rc_tick, osc_clk_en, instr_clk_en;
	logic peripheral_time_base_en, low_power_internal_rc_ref_en, aux_clk_en, pll_active;
	logic primary_output_pin_is_io, primary_xtal_drive, primary_hs_gain;
	logic [5:0] fast_rc_tune;
	int n_fail = 0;
	int cmp_count = 0;
	int no, ni, nl, na;

	oscsel_top oscsel_top_inst (
		.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .initial_source_sel,
		.primary_mode_sel, .second_pin_function_cfg,
		.fast_internal_rc_tick, .primary_input_pin,
		.secondary_input_pin, .low_power_internal_rc_tick,
		.auxiliary_source_tick, .osc_clk_en, .instr_clk_en,
		.peripheral_time_base_en, .low_power_internal_rc_ref_en, .aux_clk_en,
		.active_source, .pll_active, .primary_output_pin_is_io,
		.primary_xtal_drive, .primary_hs_gain, .fast_rc_tune
	);
	oscsel_osc_model oscsel_osc_model_inst (
		.fast_internal_rc_tick, .primary_input_pin,
		.secondary_input_pin, .low_power_internal_rc_tick,
		.auxiliary_source_tick
	);

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task near(input int seen, input int exp);
		int tol;
		tol = 3 + exp / 64;
		chk(32'(seen <= exp + tol && seen >= exp - tol), 32'h1);
	endtask : near

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(32'(n < 50), 32'h1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rst(input logic [2:0] s, input logic [1:0] m, input logic c);
		arst_n <= 1'b0;
		initial_source_sel <= s;
		primary_mode_sel <= m;
		second_pin_function_cfg <= c;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask : rst

	task meas;
		no = 0;
		ni = 0;
		nl = 0;
		na = 0;
		repeat (300) @(posedge mclk);
		repeat (2560)
		begin
			@(posedge mclk);
			no += int'(osc_clk_en);
			ni += int'(instr_clk_en);
			nl += int'(low_power_internal_rc_ref_en);
			na += int'(aux_clk_en);
		end
	endtask : meas

	task t_regs;
		apb(1'b0, ADDR_CLOCK_DIVISOR_REG, 32'h0);
		chk(rd, 32'h40);
		apb(1'b0, ADDR_FEEDBACK_DIVISOR_REG, 32'h0);
		chk(rd, 32'h30);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(rd[2:0]), 32'h7);
		apb(1'b1, ADDR_CLOCK_DIVISOR_REG, 32'h71f);
		apb(1'b0, ADDR_CLOCK_DIVISOR_REG, 32'h0);
		chk(rd, 32'h71f);
		apb(1'b1, ADDR_TUNE, 32'h2a);
		@(negedge mclk);
		chk(32'(fast_rc_tune), 32'h2a);
		apb(1'b1, ADDR_STATUS, 32'h0);
		chk(32'(rerr), 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(rerr), 32'h1);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_src;
		int e[8] = '{256, 512, 213, 426, 160, 128, 16, 256};
		for (int s = 0; s < 8; s++)
		begin
			rst(3'(s), 2'h1, 1'b0);
			apb(1'b1, ADDR_CLOCK_DIVISOR_REG, 32'h0);
			apb(1'b1, ADDR_FEEDBACK_DIVISOR_REG, 32'h6);
			meas();
			chk(32'(active_source), 32'(s));
			chk(32'(pll_active), 32'(s == 1 || s == 3));
			near(no, e[s]);
			near(ni, e[s] / 2);
		end
		near(nl, 128);
		near(na, 182);
		$display("t_src done");
	endtask : t_src

	task automatic t_div;
		int e[8] = '{256, 128, 64, 32, 16, 8, 4, 1};
		rst(3'h7, 2'h3, 1'b1);
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b1, ADDR_CLOCK_DIVISOR_REG, 32'(k) << 8);
			meas();
			near(no, e[k]);
		end
		rst(3'h6, 2'h3, 1'b1);
		apb(1'b1, ADDR_CLOCK_DIVISOR_REG, 32'h100);
		meas();
		near(no, 16);
		$display("t_div done");
	endtask : t_div

	task automatic t_pll;
		logic [31:0] cd[4] = '{32'hdf, 32'h41, 32'h80, 32'hc0};
		logic [31:0] fb[4] = '{32'h62, 32'h4, 32'h2, 32'h0};
		int e[4] = '{97, 128, 128, 32};
		rst(3'h1, 2'h3, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, ADDR_CLOCK_DIVISOR_REG, cd[i]);
			apb(1'b1, ADDR_FEEDBACK_DIVISOR_REG, fb[i]);
			meas();
			near(no, e[i]);
		end
		$display("t_pll done");
	endtask : t_pll

	task automatic t_pins;
		logic [5:0] cf[5] = '{6'h15, 6'h1b, 6'h11, 6'h25, 6'h02};
		logic [2:0] e[5] = '{3'h3, 3'h2, 3'h4, 3'h4, 3'h0};
		for (int i = 0; i < 5; i++)
		begin
			rst(cf[i][5:3], cf[i][2:1], cf[i][0]);
			v = {primary_output_pin_is_io, primary_xtal_drive,
				primary_hs_gain};
			chk(32'(v), 32'(e[i]));
		end
		$display("t_pins done");
	endtask : t_pins

	task wrap_up;
		$display("Compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	initial
	begin
		#400000;
		n_fail++;
		wrap_up();
	end

	initial
	begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		initial_source_sel = 3'h7;
		primary_mode_sel = 2'h3;
		second_pin_function_cfg = 1'b1;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_regs();
		t_src();
		t_div();
		t_pll();
		t_pins();
		wrap_up();
	end
endmodule : oscsel_top_test
